// ===== design/miip_params.svh
`ifndef MIIP_PARAMS_SVH
`define MIIP_PARAMS_SVH
// Nibble width on both data buses.
`define MIIP_NIBBLE_W 4
// Clock rate of clk_in in kHz and the management clock half period in ns.
`define MIIP_CLK_KHZ 25000
`define MIIP_MDC_HALF_NS 200
// Half period of the management clock in clk_in cycles, rounded down, at least one.
`define MIIP_MDC_HALF_CYC ((`MIIP_MDC_HALF_NS * `MIIP_CLK_KHZ / 1000000) < 1 ? 1 : \
   (`MIIP_MDC_HALF_NS * `MIIP_CLK_KHZ / 1000000))
// Management frame length in bits and the bit at which the device turns the line round.
`define MIIP_MGMT_BITS 64
`define MIIP_MGMT_TURN_BIT 46
// Buffer depth in words.
`define MIIP_BUF_DEPTH 2
`endif

// ===== design/miip_pkg.sv
package miip_pkg;
   // Transmit sequencer states.
   typedef enum logic [1:0] {
      MIIP_TX_IDLE,
      MIIP_TX_LOW,
      MIIP_TX_HIGH
   } miip_tx_state_type;
   // Management sequencer states.
   typedef enum logic [1:0] {
      MIIP_MG_IDLE,
      MIIP_MG_SHIFT,
      MIIP_MG_DONE
   } miip_mg_state_type;
endpackage

// ===== design/miip_buf_if.sv
`timescale 1ns/100ps
`default_nettype none
interface miip_buf_if #(parameter int WIDTH = 9);
   logic [WIDTH-1:0] wr_data;
   logic wr_valid;
   logic wr_ready;
   logic [WIDTH-1:0] rd_data;
   logic rd_valid;
   logic rd_ready;
   modport store (input wr_data, input wr_valid, output wr_ready,
      output rd_data, output rd_valid, input rd_ready);
   modport user (output wr_data, output wr_valid, input wr_ready,
      input rd_data, input rd_valid, output rd_ready);
endinterface
`default_nettype wire

// ===== design/miip_buffer.sv
`timescale 1ns/100ps
`default_nettype none
`include "miip_params.svh"
module miip_buffer #(
   parameter int WIDTH = 9,
   parameter int DEPTH = `MIIP_BUF_DEPTH
) (
   // Clock, reset and enable.
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic enable_in,
   // Both sides of the store.
   miip_buf_if.store port
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic do_wr;
   logic do_rd;

   ////////////////////////////////////////////////////////////////////////////
   // Full and empty come from the word count, so both are exact.
   assign port.wr_ready = (count != (AW+1)'(DEPTH));
   assign port.rd_valid = (count != '0);
   assign port.rd_data = mem[rd_ptr];
   assign do_wr = port.wr_valid && port.wr_ready;
   assign do_rd = port.rd_valid && port.rd_ready;

   // Storage entries, written one per accepted word.
   always_ff @(posedge clk_in) begin
      if (enable_in && do_wr) begin
         mem[wr_ptr] <= port.wr_data;
      end
   end

   // Pointers and count.
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else if (enable_in) begin
         if (do_wr) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
         end
         if (do_rd) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
         end
         count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
      end
   end
endmodule
`default_nettype wire

// ===== design/miip_mii_port.sv
`timescale 1ns/100ps
`default_nettype none
`include "miip_params.svh"
// Overview of operation
// R1 - Transmit frame data as four-bit nibbles.
// R2 - Transmit enable high only for data nibbles.
// R3 - Coding error with enable forces invalid symbols.
// R4 - PHY transmit clock times transmit outputs.
// R5 - PHY receive clock times receive sampling.
// R6 - Receive data accepted as nibbles.
// R7 - Nibbles count only while receive valid.
// R8 - Receive error marks current frame errored.
// R9 - PHY raises carrier on busy medium.
// R10 - PHY raises collision when detected.
// R11 - Device drives management clock for bits.
// R12 - Management data line is bidirectional.
// R13 - Launch on transmit clock, sample on receive rise.
// R14 - Synchronise carrier and collision before use.
module miip_mii_port #(
   parameter int NIB_W = `MIIP_NIBBLE_W,
   parameter int MGMT_BITS = `MIIP_MGMT_BITS,
   parameter int TURN_BIT = `MIIP_MGMT_TURN_BIT
) (
   // Clock, reset and enable.
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic enable_in,
   // User transmit side: one byte per word, low nibble sent first.
   input wire logic [7:0] tx_byte_in,
   input wire logic tx_error_in,
   input wire logic tx_last_in,
   input wire logic tx_valid_in,
   output logic tx_ready_out,
   // User receive side.
   output logic [NIB_W-1:0] rx_nibble_out,
   output logic rx_valid_out,
   output logic rx_frame_end_out,
   output logic rx_frame_error_out,
   input wire logic rx_ready_in,
   // Medium status toward the user.
   output logic carrier_out,
   output logic collision_out,
   // User management command.
   input wire logic [MGMT_BITS-1:0] mgmt_frame_in,
   input wire logic mgmt_start_in,
   output logic mgmt_busy_out,
   output logic [15:0] mgmt_read_data_out,
   // PHY transmit pins.
   input wire logic phy_transmit_clock_in,
   output logic [NIB_W-1:0] transmit_nibble_out,
   output logic transmit_enable_out,
   output logic transmit_coding_error_out,
   // PHY receive pins.
   input wire logic phy_receive_clock_in,
   input wire logic [NIB_W-1:0] phy_receive_nibble_in,
   input wire logic phy_receive_valid_in,
   input wire logic phy_receive_error_in,
   input wire logic phy_carrier_sense_in,
   input wire logic phy_collision_in,
   // Management pins.
   output logic mgmt_clock_out,
   input wire logic mgmt_data_in,
   output logic mgmt_data_out,
   output logic mgmt_data_oe_out
);
   localparam int MDC_HALF = `MIIP_MDC_HALF_CYC;
   localparam int SW = NIB_W + 7;

   ////////////////////////////////////////////////////////////////////////////
   // Two flip-flop synchronisers for every pin input.
   logic [SW-1:0] sync1;
   logic [SW-1:0] sync2;
   logic [SW-1:0] pins;
   assign pins = {phy_transmit_clock_in, phy_receive_clock_in, phy_receive_nibble_in,
      phy_receive_valid_in, phy_receive_error_in, phy_carrier_sense_in,
      phy_collision_in, mgmt_data_in};

   // The first stage feeds only the second stage.
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         sync1 <= '0;
         sync2 <= '0;
      end else if (enable_in) begin
         sync1 <= pins;
         sync2 <= sync1;
      end
   end

   logic txc;
   logic rxc;
   logic [NIB_W-1:0] rxd;
   logic rxdv;
   logic rxer;
   logic mdi;
   logic txc_d;
   logic rxc_d;
   assign txc = sync2[SW-1];
   assign rxc = sync2[SW-2];
   assign rxd = sync2[SW-3 -: NIB_W];
   assign rxdv = sync2[4];
   assign rxer = sync2[3];
   assign mdi = sync2[0];

   // Edge history of both link clocks.
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         txc_d <= 1'b0;
         rxc_d <= 1'b0;
      end else if (enable_in) begin
         txc_d <= txc;
         rxc_d <= rxc;
      end
   end

   logic tx_fall;
   logic rx_rise;
   assign tx_fall = txc_d && !txc; // Launch on falling edge so the PHY samples on rising.
   assign rx_rise = rxc && !rxc_d;

   // Carrier and collision are only used after synchronising.
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         carrier_out <= 1'b0;
         collision_out <= 1'b0;
      end else if (enable_in) begin
         carrier_out <= sync2[2]; // see R14
         collision_out <= sync2[1]; // see R14
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmit path: byte split into two nibbles, launched on the PHY clock.
   miip_pkg::miip_tx_state_type tx_state;
   logic [7:0] tx_hold;
   logic tx_hold_err;
   assign tx_ready_out = (tx_state == miip_pkg::MIIP_TX_IDLE) ||
      (tx_state == miip_pkg::MIIP_TX_HIGH && tx_fall);

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         tx_state <= miip_pkg::MIIP_TX_IDLE;
         tx_hold <= 8'h00;
         tx_hold_err <= 1'b0;
         transmit_nibble_out <= '0;
         transmit_enable_out <= 1'b0;
         transmit_coding_error_out <= 1'b0;
      end else if (enable_in) begin
         if (tx_ready_out && tx_valid_in) begin
            tx_hold <= tx_byte_in;
            tx_hold_err <= tx_error_in;
         end
         unique case (tx_state)
            miip_pkg::MIIP_TX_IDLE: begin
               if (tx_valid_in) begin
                  tx_state <= miip_pkg::MIIP_TX_LOW;
               end
               if (tx_fall) begin
                  transmit_enable_out <= 1'b0; // see R2
                  transmit_coding_error_out <= 1'b0;
               end
            end
            miip_pkg::MIIP_TX_LOW: begin
               if (tx_fall) begin
                  transmit_nibble_out <= tx_hold[NIB_W-1:0]; // see R1, R13
                  transmit_enable_out <= 1'b1; // see R2
                  transmit_coding_error_out <= tx_hold_err; // see R3
                  tx_state <= miip_pkg::MIIP_TX_HIGH;
               end
            end
            miip_pkg::MIIP_TX_HIGH: begin
               if (tx_fall) begin
                  transmit_nibble_out <= tx_hold[7 -: NIB_W]; // see R1, R13
                  transmit_coding_error_out <= tx_hold_err; // see R3
                  tx_state <= tx_valid_in ? miip_pkg::MIIP_TX_LOW : miip_pkg::MIIP_TX_IDLE;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receive path: nibbles sampled on receive clock rise into a small buffer.
   miip_buf_if #(.WIDTH(NIB_W + 2)) rxb ();
   logic rx_in_frame;
   logic rx_err_seen;

   miip_buffer #(.WIDTH(NIB_W + 2)) rx_store (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .enable_in(enable_in),
      .port(rxb.store)
   );

   // The error flag sticks for the frame; set wins over the start-of-frame clear.
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         rx_in_frame <= 1'b0;
         rx_err_seen <= 1'b0;
      end else if (enable_in && rx_rise) begin
         rx_in_frame <= rxdv;
         if (rxer && rxdv) begin
            rx_err_seen <= 1'b1; // see R8
         end else if (!rx_in_frame && rxdv) begin
            rx_err_seen <= 1'b0;
         end
      end
   end

   // A word whose valid is low carries the end-of-frame marker and the frame's sticky error flag.
   assign rxb.wr_valid = rx_rise && (rxdv || rx_in_frame); // see R5, R7, R13
   // The sticky flag only counts inside a frame, so a new frame never inherits an old error.
   assign rxb.wr_data = {rx_in_frame && !rxdv, (rx_err_seen && rx_in_frame) || (rxer && rxdv),
      rxd}; // see R6
   assign rxb.rd_ready = !rx_valid_out || rx_ready_in;

   // Output register stage; a full buffer drops the nibble, which a 25 MHz user avoids.
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         rx_valid_out <= 1'b0;
         rx_nibble_out <= '0;
         rx_frame_end_out <= 1'b0;
         rx_frame_error_out <= 1'b0;
      end else if (enable_in && rxb.rd_ready) begin
         rx_valid_out <= rxb.rd_valid;
         rx_nibble_out <= rxb.rd_data[NIB_W-1:0];
         rx_frame_error_out <= rxb.rd_data[NIB_W]; // see R8
         rx_frame_end_out <= rxb.rd_data[NIB_W+1];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Management port: divided clock, shift out, turn round for read data.
   miip_pkg::miip_mg_state_type mg_state;
   logic [MGMT_BITS-1:0] mg_shift;
   logic [$clog2(MGMT_BITS+1)-1:0] mg_bit;
   logic [$clog2(MDC_HALF+1)-1:0] mg_div;

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         mg_state <= miip_pkg::MIIP_MG_IDLE;
         mg_shift <= '0;
         mg_bit <= '0;
         mg_div <= '0;
         mgmt_clock_out <= 1'b0;
         mgmt_data_out <= 1'b0;
         mgmt_data_oe_out <= 1'b0;
         mgmt_read_data_out <= 16'h0000;
         mgmt_busy_out <= 1'b0;
      end else if (enable_in) begin
         unique case (mg_state)
            miip_pkg::MIIP_MG_IDLE: begin
               mgmt_clock_out <= 1'b0;
               mgmt_data_oe_out <= 1'b0;
               if (mgmt_start_in) begin
                  mg_shift <= mgmt_frame_in;
                  mg_bit <= '0;
                  mg_div <= '0;
                  mgmt_busy_out <= 1'b1;
                  mg_state <= miip_pkg::MIIP_MG_SHIFT;
               end
            end
            miip_pkg::MIIP_MG_SHIFT: begin
               if (mg_div == ($bits(mg_div))'(MDC_HALF - 1)) begin
                  mg_div <= '0;
                  mgmt_clock_out <= !mgmt_clock_out; // see R11
                  if (!mgmt_clock_out) begin
                     // Rising edge: PHY samples our bit, we sample its bit.
                     mgmt_read_data_out <= {mgmt_read_data_out[14:0], mdi}; // see R12
                  end else begin
                     // Falling edge: launch next bit or release the line.
                     // Ending here rather than on a rise keeps the last high phase full length.
                     if (mg_bit == ($bits(mg_bit))'(MGMT_BITS)) begin
                        mg_state <= miip_pkg::MIIP_MG_DONE;
                     end
                     mgmt_data_out <= mg_shift[MGMT_BITS-1];
                     mgmt_data_oe_out <= (mg_bit < ($bits(mg_bit))'(TURN_BIT)); // see R12
                     mg_shift <= {mg_shift[MGMT_BITS-2:0], 1'b0};
                     mg_bit <= mg_bit + 1'b1;
                  end
               end else begin
                  mg_div <= mg_div + 1'b1;
               end
            end
            miip_pkg::MIIP_MG_DONE: begin
               mgmt_clock_out <= 1'b0;
               mgmt_busy_out <= 1'b0;
               mgmt_data_oe_out <= 1'b0;
               mg_state <= miip_pkg::MIIP_MG_IDLE;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// ===== tb/miip_mii_port_props.sv
`timescale 1ns/100ps
`default_nettype none
module miip_mii_port_props #(
   parameter int NIB_W = 4
) (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic reset_in,
   // Transmit side.
   input wire logic tx_valid_in,
   input wire logic tx_ready_out,
   input wire logic [NIB_W-1:0] transmit_nibble_out,
   input wire logic transmit_enable_out,
   // Receive side and medium status.
   input wire logic phy_receive_valid_in,
   input wire logic rx_ready_in,
   input wire logic rx_valid_out,
   input wire logic phy_carrier_sense_in,
   input wire logic carrier_out,
   input wire logic phy_collision_in,
   input wire logic collision_out,
   // Management side.
   input wire logic mgmt_clock_out,
   input wire logic mgmt_busy_out,
   input wire logic mgmt_data_oe_out
);
   // Everything here lives in the system clock domain.
   default clocking dc @(posedge clk_in);
   endclocking
   default disable iff (reset_in);
   // The high phase of the management clock lasts at least the chosen half period.
   sequence s_mdc_high;
      mgmt_clock_out [*5];
   endsequence
   ////////////////////////////////////////////////////////////
   // A nibble must stand a whole transmit clock period, so the PHY never sees it mid-change.
   a_tx_nibble_hold: assert property ($changed(transmit_nibble_out) |=>
      $stable(transmit_nibble_out) [*7]) else $error("transmit nibble held too briefly");
   a_tx_enable_span: assert property ($rose(transmit_enable_out) |->
      transmit_enable_out [*8]) else $error("transmit enable dropped inside a byte");
   a_tx_accept_start: assert property (tx_valid_in && tx_ready_out |->
      ##[1:14] transmit_enable_out) else $error("accepted byte never reached the pins");
   a_mdc_half_period: assert property ($rose(mgmt_clock_out) |->
      s_mdc_high ##[1:8] !mgmt_clock_out) else $error("management clock half period wrong");
   a_mdio_turn_frame: assert property ($fell(mgmt_data_oe_out) |->
      mgmt_busy_out) else $error("data line released outside a frame");
   a_carrier_sync: assert property ($rose(phy_carrier_sense_in) |->
      ##[2:5] carrier_out) else $error("carrier not passed through the synchroniser");
   a_collision_clear: assert property ($fell(phy_collision_in) |->
      ##[2:5] !collision_out) else $error("collision not cleared after the synchroniser");
   a_rx_valid_path: assert property (phy_receive_valid_in && rx_ready_in |->
      ##[1:30] rx_valid_out) else $error("received nibbles never reached the user");
endmodule
bind miip_mii_port miip_mii_port_props #(.NIB_W(NIB_W)) u_props (.clk_in, .reset_in,
   .tx_valid_in, .tx_ready_out, .transmit_nibble_out, .transmit_enable_out,
   .phy_receive_valid_in, .rx_ready_in, .rx_valid_out, .phy_carrier_sense_in, .carrier_out,
   .phy_collision_in, .collision_out, .mgmt_clock_out, .mgmt_busy_out, .mgmt_data_oe_out);
`default_nettype wire

// ===== tb/miip_phy_model.sv
`timescale 1ns/100ps
`default_nettype none
module miip_phy_model #(
   parameter logic [15:0] READ_VALUE = 16'h0000
) (
   // Clocks and receive pins toward the device.
   output logic tx_clk_out,
   output logic rx_clk_out,
   output logic [3:0] rx_nibble_out,
   output logic rx_valid_out,
   output logic rx_error_out,
   // Transmit pins from the device.
   input wire logic [3:0] tx_nibble_in,
   input wire logic tx_enable_in,
   input wire logic tx_error_in,
   // Management pins; the line has a pull-up.
   input wire logic mdc_in,
   input wire logic mdio_dev_in,
   input wire logic mdio_oe_in,
   output logic mdio_line_out
);
   logic [4:0] tx_seen[$];
   logic [45:0] mgmt_cap;
   int rises;
   logic drive, drive_bit;
   // Both clocks run free, unrelated in phase to each other and to the system clock.
   initial begin
      tx_clk_out = 1'b0;
      rx_clk_out = 1'b0;
      {rx_nibble_out, rx_valid_out, rx_error_out, drive, drive_bit} = 8'h00;
      rises = 0;
      mgmt_cap = '0;
      #13;
      fork
         forever #160 tx_clk_out = ~tx_clk_out;
         begin #97; forever #160 rx_clk_out = ~rx_clk_out; end
      join
   end
   // Sample the transmit pins on the rising edge, about 73 ns after the device has launched them.
   always @(posedge tx_clk_out) if (tx_enable_in) tx_seen.push_back({tx_error_in, tx_nibble_in});
   // Launch a frame nibble by nibble on falling receive clock edges, then scramble the idle bus.
   task automatic send_frame(input int count, input int bad);
      for (int i = 0; i < count; i++) begin
         @(negedge rx_clk_out);
         rx_nibble_out = 4'(i + 1);
         rx_valid_out = 1'b1;
         rx_error_out = (i == bad);
      end
      @(negedge rx_clk_out);
      rx_valid_out = 1'b0;
      rx_error_out = 1'b0;
      rx_nibble_out = ~rx_nibble_out;
   endtask
   // Wire level: device, then this model, then the pull-up.
   assign mdio_line_out = mdio_oe_in ? mdio_dev_in : (drive ? drive_bit : 1'b1);
   always @(posedge mdc_in) begin
      // The device's first rise comes before its first bit, so capture starts one rise later.
      if (rises >= 1 && rises <= 46) mgmt_cap <= {mgmt_cap[44:0], mdio_line_out};
      rises <= rises + 1;
   end
   // After the turnaround bit, answer with a zero and then the read value, most significant first.
   always @(negedge mdc_in) begin
      drive <= rises >= 48 && rises <= 64;
      drive_bit <= (rises < 49 || rises > 64) ? 1'b0 : READ_VALUE[64 - rises];
   end
endmodule
`default_nettype wire

// ===== tb/miip_mii_port_tb.sv
`timescale 1ns/100ps
`default_nettype none
module miip_mii_port_tb;
   logic clk_in, reset_in, enable_in, tx_error_in, tx_last_in, tx_valid_in, rx_ready_in;
   logic mgmt_start_in, phy_carrier_sense_in, phy_collision_in, mgmt_data_in;
   logic [7:0] tx_byte_in;
   logic [63:0] mgmt_frame_in;
   logic tx_ready_out, rx_valid_out, rx_frame_end_out, rx_frame_error_out, carrier_out;
   logic collision_out, mgmt_busy_out, transmit_enable_out, transmit_coding_error_out;
   logic mgmt_clock_out, mgmt_data_out, mgmt_data_oe_out, phy_transmit_clock_in;
   logic phy_receive_clock_in, phy_receive_valid_in, phy_receive_error_in;
   logic [3:0] rx_nibble_out, transmit_nibble_out, phy_receive_nibble_in;
   logic [15:0] mgmt_read_data_out;
   logic [5:0] rx_seen[$];
   logic [4:0] exp_tx[4] = '{5'h05, 5'h0A, 5'h1C, 5'h13};
   int miscompares, comparisons;
   miip_mii_port u_dut (.clk_in, .reset_in, .enable_in, .tx_byte_in, .tx_error_in, .tx_last_in,
      .tx_valid_in, .tx_ready_out, .rx_nibble_out, .rx_valid_out, .rx_frame_end_out,
      .rx_frame_error_out, .rx_ready_in, .carrier_out, .collision_out, .mgmt_frame_in,
      .mgmt_start_in, .mgmt_busy_out, .mgmt_read_data_out, .phy_transmit_clock_in,
      .transmit_nibble_out, .transmit_enable_out, .transmit_coding_error_out,
      .phy_receive_clock_in, .phy_receive_nibble_in, .phy_receive_valid_in,
      .phy_receive_error_in, .phy_carrier_sense_in, .phy_collision_in, .mgmt_clock_out,
      .mgmt_data_in, .mgmt_data_out, .mgmt_data_oe_out);
   miip_phy_model #(.READ_VALUE(16'hC3A5)) u_phy (.tx_clk_out(phy_transmit_clock_in),
      .rx_clk_out(phy_receive_clock_in), .rx_nibble_out(phy_receive_nibble_in),
      .rx_valid_out(phy_receive_valid_in), .rx_error_out(phy_receive_error_in),
      .tx_nibble_in(transmit_nibble_out), .tx_enable_in(transmit_enable_out),
      .tx_error_in(transmit_coding_error_out), .mdc_in(mgmt_clock_out),
      .mdio_dev_in(mgmt_data_out), .mdio_oe_in(mgmt_data_oe_out), .mdio_line_out(mgmt_data_in));
   ////////////////////////////////////////////////////////////
   initial begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end
   // Every word handed to the user is logged, so a dropped or extra word shows in the count.
   always @(posedge clk_in) if (rx_valid_out && rx_ready_in) rx_seen.push_back(
      {rx_frame_end_out, rx_frame_error_out, rx_nibble_out});
   task automatic check_val(input logic [63:0] got, input logic [63:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic check_flag(input logic got, input logic exp, input string what);
      check_val({63'h0, got}, {63'h0, exp}, what);
   endtask
   // Offer a byte and hold it until the edge at which it is taken.
   task automatic send_byte(input logic [7:0] b, input logic e);
      tx_byte_in <= b;
      tx_error_in <= e;
      tx_valid_in <= 1'b1;
      @(negedge clk_in);
      for (int n = 0; n < 40 && tx_ready_out !== 1'b1; n++) @(negedge clk_in);
      check_flag(tx_ready_out, 1'b1, "transmit ready");
      @(posedge clk_in);
   endtask
   // Two bytes back to back, the second flagged as a coding error.
   task automatic test_transmit();
      send_byte(8'hA5, 1'b0);
      send_byte(8'h3C, 1'b1);
      tx_valid_in <= 1'b0;
      repeat (40) @(posedge clk_in);
      check_val(u_phy.tx_seen.size(), 4, "transmit nibble count");
      for (int i = 0; i < 4; i++) check_val(u_phy.tx_seen[i], exp_tx[i], "nibble");
      $display("test_transmit done");
   endtask
   // A six nibble frame with a receive error on the third, while the user stalls at first.
   task automatic test_receive();
      rx_ready_in <= 1'b0;
      fork
         u_phy.send_frame(6, 2);
         begin repeat (20) @(posedge clk_in); rx_ready_in <= 1'b1; end
      join
      repeat (30) @(posedge clk_in);
      check_val(rx_seen.size(), 7, "receive word count");
      for (int i = 0; i < 6; i++) check_val(rx_seen[i][3:0], i + 1, "receive nibble");
      check_flag(rx_seen[1][4], 1'b0, "clean nibble flagged");
      check_flag(rx_seen[2][4], 1'b1, "errored nibble clean");
      check_flag(rx_seen[5][4], 1'b1, "error not sticky");
      check_val(rx_seen[6][5:4], 2'b11, "end marker");
      $display("test_receive done");
   endtask
   // Carrier and collision both pass the synchroniser and clear again.
   task automatic test_status();
      phy_carrier_sense_in <= 1'b1;
      phy_collision_in <= 1'b1;
      repeat (6) @(posedge clk_in);
      check_flag(carrier_out, 1'b1, "carrier");
      check_flag(collision_out, 1'b1, "collision");
      phy_carrier_sense_in <= 1'b0;
      phy_collision_in <= 1'b0;
      repeat (6) @(posedge clk_in);
      check_val({carrier_out, collision_out}, 2'b00, "status clear");
      $display("test_status done");
   endtask
   // One read frame: the head goes out on the line, the PHY answers after the turnaround.
   task automatic test_mgmt();
      mgmt_frame_in <= 64'h6A1B_2C3D_5E4F_7081;
      mgmt_start_in <= 1'b1;
      @(posedge clk_in);
      mgmt_start_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      check_flag(mgmt_busy_out, 1'b1, "management busy");
      for (int n = 0; n < 1500 && mgmt_busy_out !== 1'b0; n++) @(negedge clk_in);
      check_flag(mgmt_busy_out, 1'b0, "management idle");
      check_val(u_phy.mgmt_cap, mgmt_frame_in[63:18], "management head");
      check_val(mgmt_read_data_out, 16'hC3A5, "management read data");
      $display("test_mgmt done");
   endtask
   task automatic stop_test();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // The tests need about 32 us; over fifteen times that means something hangs.
   initial begin
      #500000;
      miscompares++;
      stop_test();
   end
   initial begin
      {reset_in, enable_in, tx_error_in, tx_last_in, tx_valid_in, rx_ready_in} = 6'h31;
      {mgmt_start_in, phy_carrier_sense_in, phy_collision_in, tx_byte_in} = 11'h000;
      mgmt_frame_in = 64'h0;
      miscompares = 0;
      comparisons = 0;
      repeat (12) @(posedge clk_in);
      reset_in <= 1'b0;
      @(posedge clk_in);
      test_transmit();
      test_receive();
      test_status();
      test_mgmt();
      stop_test();
   end
endmodule
`default_nettype wire
